/* core/psp_pkg.sv */
package psp_pkg;
    // ****************************************************************
    // time base and widths
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 8; // 125 MHz system clock
    localparam int TICK_TIME_NS = 100000000; // 0.1 s per setting unit
    localparam int TICK_CYC = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int DW = 16; // register and data width
    localparam int AW = 5; // register index width
    localparam logic [15:0] PCT_ONE = 16'h03E8; // 100.0 % in 0.1 % units
    localparam logic [15:0] CNT_MAX = 16'hFFFF; // timer saturation
    // ****************************************************************
    // register indices
    // ****************************************************************
    localparam logic [4:0] R_CTRL = 5'h00;
    localparam logic [4:0] R_SETP = 5'h01;
    localparam logic [4:0] R_SMPL = 5'h02;
    localparam logic [4:0] R_DEVL = 5'h03;
    localparam logic [4:0] R_PRSF = 5'h04;
    localparam logic [4:0] R_HOLD = 5'h05;
    localparam logic [4:0] R_SLTH = 5'h06;
    localparam logic [4:0] R_WKTH = 5'h07;
    localparam logic [4:0] R_SLDL = 5'h08;
    localparam logic [4:0] R_WKDL = 5'h09;
    localparam logic [4:0] R_SLDV = 5'h0A;
    localparam logic [4:0] R_BSDL = 5'h0B;
    localparam logic [4:0] R_HITH = 5'h0C;
    localparam logic [4:0] R_LOTH = 5'h0D;
    localparam logic [4:0] R_RCNT = 5'h0E;
    localparam logic [4:0] R_RINT = 5'h0F;
    localparam logic [4:0] R_BRKV = 5'h10;
    localparam logic [4:0] R_LOWF = 5'h11;
    localparam logic [4:0] R_STAT = 5'h12;
    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int C_EN = 0; // pid enable
    localparam int C_POL = 1; // polarity, bits 2:1
    localparam int C_SLP = 3; // sleep mode, bits 4:3
    localparam int C_AVR = 5; // voltage regulation mode, bits 6:5
    localparam int C_FAN = 7; // fan mode
    localparam int C_MRST = 8; // manual fault reset, write pulse
    localparam logic [1:0] POL_POS = 2'h1;
    localparam logic [1:0] SLP_NORM = 2'h1;
    localparam logic [1:0] SLP_DIST = 2'h2;
    localparam logic [1:0] AVR_ALL = 2'h1;
    localparam logic [1:0] AVR_NDEC = 2'h2;
    localparam logic [15:0] RCNT_UNLIM = 16'h0064; // 100 = no limit
    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] CTRL_RST = 16'h000A; // positive, normal sleep
    localparam logic [15:0] SLTH_RST = 16'h03E8; // 100.0 %
    localparam logic [15:0] WKTH_RST = 16'h0384; // 90.0 %
    localparam logic [15:0] DLY_RST = 16'h000A; // 1.0 s
    localparam logic [15:0] HITH_RST = 16'h05DC; // 150.0 %
    localparam logic [15:0] LOTH_RST = 16'h01F4; // 50.0 %
    localparam logic [15:0] RINT_RST = 16'h001E; // 3.0 s
    localparam logic [15:0] BRKV_RST = 16'h0E10; // 360.0 V
    // ****************************************************************
    // supervisor states, gray along idle-hold-run-sleep
    // ****************************************************************
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_HOLD = 3'h1,
        S_RUN = 3'h3,
        S_SLEEP = 3'h2,
        S_FAULT = 3'h6
    } psp_state_t;
    // scaled product for percentage comparisons
    function automatic logic [31:0] psp_mul(input logic [15:0] a,
                                            input logic [15:0] b);
        return 32'(a) * 32'(b);
    endfunction
endpackage

/* core/psp_tick.sv */
`timescale 1ns/1ps
// ********************************************************************
// 0.1 s tick generator
// ********************************************************************
module psp_tick import psp_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    output logic tick
);
    logic [31:0] cnt_q; // cycles since last tick
    logic [31:0] cnt_d;

    // wrap at the tick length; a short value speeds up simulation
    always_comb begin
        if (cnt_q >= 32'(TICK_CYCLES - 1)) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick = (cnt_q == '0);
endmodule // psp_tick

/* core/psp_dly.sv */
`timescale 1ns/1ps
// ********************************************************************
// persistence delay: condition must hold for lim ticks
// ********************************************************************
module psp_dly import psp_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic run,
    input wire logic [15:0] lim,
    output logic done
);
    logic [15:0] cnt_q; // elapsed ticks while run holds
    logic [15:0] cnt_d;

    // any lapse of run restarts the count from zero
    always_comb begin
        cnt_d = cnt_q;
        if (!run) begin
            cnt_d = '0;
        end else if (tick && cnt_q < lim && cnt_q != CNT_MAX) begin
            cnt_d = cnt_q + 16'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // a zero limit fires at once
    assign done = run && (cnt_q >= lim);
endmodule // psp_dly

/* core/psp_sup.sv */
`timescale 1ns/1ps
module psp_sup import psp_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DW-1:0] rdata,
    input wire logic [15:0] feedback,
    input wire logic [15:0] pid_freq,
    input wire logic drive_fault,
    input wire logic power_module_fault,
    input wire logic ext_fault,
    input wire logic decel,
    input wire logic [15:0] vout_cmd,
    input wire logic [15:0] vin,
    input wire logic [15:0] vbus,
    input wire logic fan_hot,
    output logic [15:0] freq_cmd,
    output logic signed [16:0] pid_err,
    output logic pid_sample,
    output logic pid_hold,
    output logic pipe_burst_fault,
    output logic auto_voltage_regulation,
    output logic fan_on,
    output logic brake_on
);
    // ****************************************************************
    // settings registers
    // ****************************************************************
    logic [15:0] ctl_q, ctl_d; // control bits
    logic [15:0] cfg_q [R_SETP:R_LOWF]; // numeric settings
    logic [15:0] cfg_d [R_SETP:R_LOWF];
    logic [15:0] rdata_q, rdata_d; // read data, one cycle after rd
    logic mrst; // manual reset pulse
    logic tick;
    psp_state_t st_q, st_d; // supervisor state
    logic [15:0] tries_q, tries_d; // automatic resets done
    logic hard_q, hard_d; // fault not eligible for auto reset
    logic burst_q, burst_d;
    logic [15:0] freq_q, freq_d;
    logic signed [16:0] err_q, err_d;
    logic smp_q, smp_d, hld_q, hld_d;
    logic avr_q, avr_d, fan_q, fan_d, brk_q, brk_d;
    logic [15:0] sp;
    logic [1:0] pol, slm, avm;
    logic in_band, slp_band, slp_cond, wk_cond, bst_hi, bst_lo, bst_cond;
    logic fault_in, auto_ok, any_err;
    logic hold_done, smp_done, slp_done, wk_done, bst_done, rst_done;

    assign sp = cfg_q[R_SETP];
    assign pol = ctl_q[C_POL+1:C_POL];
    assign slm = ctl_q[C_SLP+1:C_SLP];
    assign avm = ctl_q[C_AVR+1:C_AVR];
    assign mrst = wr && addr == R_CTRL && wdata[C_MRST];

    // ****************************************************************
    // register port
    // ****************************************************************
    // writes land next edge; reads answer only in the following cycle
    always_comb begin
        ctl_d = ctl_q;
        cfg_d = cfg_q;
        rdata_d = '0;
        if (wr) begin
            if (addr == R_CTRL) begin
                ctl_d = wdata & ~(16'h1 << C_MRST); // reset bit self-clears
            end else if (addr >= R_SETP && addr <= R_LOWF) begin
                cfg_d[addr] = wdata;
            end
        end
        if (rd) begin
            if (addr == R_CTRL) begin
                rdata_d = ctl_q;
            end else if (addr >= R_SETP && addr <= R_LOWF) begin
                rdata_d = cfg_q[addr];
            end else if (addr == R_STAT) begin
                rdata_d = {tries_q[7:0], 2'h0, hard_q, burst_q, 1'b0,
                           st_q};
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_q <= CTRL_RST;
            for (int i = R_SETP; i <= R_LOWF; i++) begin
                cfg_q[i] <= '0;
            end
            cfg_q[R_SETP] <= '0;
            cfg_q[R_SLTH] <= SLTH_RST;
            cfg_q[R_WKTH] <= WKTH_RST;
            cfg_q[R_SLDL] <= DLY_RST;
            cfg_q[R_WKDL] <= DLY_RST;
            cfg_q[R_SLDV] <= DLY_RST;
            cfg_q[R_HITH] <= HITH_RST;
            cfg_q[R_LOTH] <= LOTH_RST;
            cfg_q[R_RINT] <= RINT_RST;
            cfg_q[R_BRKV] <= BRKV_RST;
            rdata_q <= '0;
        end else begin
            ctl_q <= ctl_d;
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;

    // ****************************************************************
    // comparisons against the setpoint
    // ****************************************************************
    // cross-multiplied so no divider is needed
    function automatic logic near_sp(input logic [15:0] fb,
                                     input logic [15:0] s,
                                     input logic [15:0] pct);
        logic [15:0] d;
        d = (fb > s) ? fb - s : s - fb;
        return psp_mul(d, PCT_ONE) <= psp_mul(s, pct);
    endfunction

    always_comb begin
        in_band = near_sp(feedback, sp, cfg_q[R_DEVL]);
        // band from the sleep deviation only counts in disturbed mode
        slp_band = (slm != SLP_DIST) ||
                   near_sp(feedback, sp, cfg_q[R_SLDV]);
        slp_cond = (slm == SLP_NORM || slm == SLP_DIST) && slp_band &&
                   psp_mul(feedback, PCT_ONE) >
                   psp_mul(sp, cfg_q[R_SLTH]) &&
                   pid_freq <= cfg_q[R_LOWF];
        if (pol == POL_POS) begin
            wk_cond = psp_mul(feedback, PCT_ONE) <
                      psp_mul(sp, cfg_q[R_WKTH]);
        end else begin
            wk_cond = psp_mul(feedback, PCT_ONE) >
                      psp_mul(sp, cfg_q[R_WKTH]);
        end
        bst_hi = psp_mul(feedback, PCT_ONE) >=
                 psp_mul(sp, cfg_q[R_HITH]);
        bst_lo = psp_mul(feedback, PCT_ONE) <
                 psp_mul(sp, cfg_q[R_LOTH]);
        bst_cond = bst_hi || bst_lo;
    end

    // ****************************************************************
    // time base and persistence timers
    // ****************************************************************
    psp_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk(clk), .resetn(resetn), .tick(tick));

    // each timer restarts if its condition drops out early
    psp_dly u_hold (.clk(clk), .resetn(resetn), .tick(tick),
        .run(st_q == S_HOLD), .lim(cfg_q[R_HOLD]),
        .done(hold_done));
    psp_dly u_smp (.clk(clk), .resetn(resetn), .tick(tick),
        .run(st_q == S_RUN && !smp_q), .lim(cfg_q[R_SMPL]),
        .done(smp_done));
    psp_dly u_slp (.clk(clk), .resetn(resetn), .tick(tick),
        .run(st_q == S_RUN && slp_cond), .lim(cfg_q[R_SLDL]),
        .done(slp_done));
    psp_dly u_wk (.clk(clk), .resetn(resetn), .tick(tick),
        .run(st_q == S_SLEEP && wk_cond), .lim(cfg_q[R_WKDL]),
        .done(wk_done));
    psp_dly u_bst (.clk(clk), .resetn(resetn), .tick(tick),
        .run(bst_cond), .lim(cfg_q[R_BSDL]),
        .done(bst_done));
    psp_dly u_rst (.clk(clk), .resetn(resetn), .tick(tick),
        .run(st_q == S_FAULT && auto_ok), .lim(cfg_q[R_RINT]),
        .done(rst_done));

    // ****************************************************************
    // supervisor state machine
    // ****************************************************************
    assign fault_in = drive_fault || power_module_fault || ext_fault;
    // retry budget: zero never, 100 forever, else bounded
    assign auto_ok = cfg_q[R_RCNT] != '0 && !hard_q &&
                     (cfg_q[R_RCNT] == RCNT_UNLIM ||
                      tries_q < cfg_q[R_RCNT]);

    always_comb begin
        st_d = st_q;
        tries_d = tries_q;
        hard_d = hard_q;
        case (st_q)
            S_IDLE: begin
                if (ctl_q[C_EN]) begin
                    st_d = S_HOLD;
                end
            end
            S_HOLD: begin
                if (hold_done) begin
                    st_d = S_RUN;
                end
            end
            S_RUN: begin
                if (slp_done) begin
                    st_d = S_SLEEP;
                end
            end
            S_SLEEP: begin
                // disturbed mode with positive polarity skips the delay
                if (wk_cond && slm == SLP_DIST && pol == POL_POS) begin
                    st_d = S_RUN;
                end else if (wk_done) begin
                    st_d = S_RUN;
                end
            end
            S_FAULT: begin
                if (mrst) begin
                    st_d = S_IDLE;
                    tries_d = '0;
                    hard_d = 1'b0;
                end else if (rst_done) begin
                    st_d = S_IDLE;
                    tries_d = tries_q + 16'h1;
                end
            end
            default: st_d = S_IDLE;
        endcase
        if (st_q != S_IDLE && st_q != S_FAULT && !ctl_q[C_EN]) begin
            st_d = S_IDLE;
        end
        // a new fault wins over any transition above
        if (fault_in && st_q != S_FAULT) begin
            st_d = S_FAULT;
            hard_d = power_module_fault || ext_fault;
        end else if (st_q == S_FAULT &&
                     (power_module_fault || ext_fault)) begin
            hard_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= S_IDLE;
            tries_q <= '0;
            hard_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tries_q <= tries_d;
            hard_q <= hard_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // burst flag follows the live condition, so it clears by itself
    always_comb begin
        burst_d = bst_done;
        any_err = st_q == S_FAULT || burst_q;
        if (any_err || st_q == S_IDLE || st_q == S_SLEEP) begin
            freq_d = '0;
        end else if (st_q == S_HOLD) begin
            freq_d = cfg_q[R_PRSF];
        end else begin
            freq_d = pid_freq;
        end
        // positive: feedback above setpoint gives negative correction
        if (pol == POL_POS) begin
            err_d = $signed({1'b0, sp}) - $signed({1'b0, feedback});
        end else begin
            err_d = $signed({1'b0, feedback}) - $signed({1'b0, sp});
        end
        hld_d = st_q != S_RUN || in_band;
        smp_d = smp_done && !in_band;
        avr_d = (avm == AVR_ALL || (avm == AVR_NDEC && !decel)) &&
                !(vout_cmd > vin);
        fan_d = ctl_q[C_FAN] || st_q == S_HOLD || st_q == S_RUN ||
                fan_hot;
        brk_d = vbus > cfg_q[R_BRKV];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            burst_q <= 1'b0;
            freq_q <= '0;
            err_q <= '0;
            hld_q <= 1'b1;
            smp_q <= 1'b0;
            avr_q <= 1'b0;
            fan_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            burst_q <= burst_d;
            freq_q <= freq_d;
            err_q <= err_d;
            hld_q <= hld_d;
            smp_q <= smp_d;
            avr_q <= avr_d;
            fan_q <= fan_d;
            brk_q <= brk_d;
        end
    end

    assign freq_cmd = freq_q;
    assign pid_err = err_q;
    assign pid_sample = smp_q;
    assign pid_hold = hld_q;
    assign pipe_burst_fault = burst_q;
    assign auto_voltage_regulation = avr_q;
    assign fan_on = fan_q;
    assign brake_on = brk_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    band_no_sample_a: assert property (
        in_band |=> !pid_sample && pid_hold)
        else $error("sample issued inside deviation band");
    sample_single_a: assert property (
        pid_sample |=> !pid_sample)
        else $error("sample pulse longer than one cycle");
    hold_preset_a: assert property (
        st_q == S_HOLD && !burst_q |=> freq_cmd == $past(cfg_q[R_PRSF]))
        else $error("preset frequency not driven during hold");
    sleep_entry_a: assert property (
        st_q == S_RUN && !fault_in ##1 st_q == S_SLEEP |->
        $past(slp_cond))
        else $error("sleep entered without sleep condition");
    wake_exit_a: assert property (
        st_q == S_SLEEP && !fault_in ##1 st_q == S_RUN |-> $past(wk_cond))
        else $error("wake without wake condition");
    burst_rise_a: assert property (
        $rose(pipe_burst_fault) |-> $past(bst_cond))
        else $error("burst fault without pressure condition");
    burst_clear_a: assert property (
        !bst_cond |=> !pipe_burst_fault)
        else $error("burst fault did not clear");
    no_auto_a: assert property (
        st_q == S_FAULT && cfg_q[R_RCNT] == '0 && !mrst |=>
        st_q == S_FAULT)
        else $error("fault cleared with zero reset count");
    hard_keep_a: assert property (
        st_q == S_FAULT && hard_q && !mrst |=> st_q == S_FAULT)
        else $error("power or external fault auto reset");
    avr_supply_a: assert property (
        vout_cmd > vin |=> !auto_voltage_regulation)
        else $error("regulation active above supply");
    brake_on_a: assert property (
        vbus > cfg_q[R_BRKV] |=> brake_on)
        else $error("braking unit not engaged");

    sleep_cycle_c: cover property (st_q == S_SLEEP ##[1:50] st_q == S_RUN);
    auto_reset_c: cover property (st_q == S_FAULT ##1 st_q == S_IDLE);
    burst_seen_c: cover property ($rose(pipe_burst_fault));
endmodule // psp_sup

/* tb/psp_plant.sv */
`timescale 1ns/1ps
// ****************************************************************
// sensor and motor stand-in
// ****************************************************************
// the sensor reports one clock late, as a sampled gauge would
module psp_plant (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] fb_set,
    input wire logic [15:0] pf_set,
    output logic [15:0] feedback,
    output logic [15:0] pid_freq
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            feedback <= 16'h0000;
            pid_freq <= 16'h0000;
        end else begin
            feedback <= fb_set;
            pid_freq <= pf_set;
        end
    end
endmodule // psp_plant

/* tb/test_pid_sleep_pressure_supervisor.sv */
`timescale 1ns/1ps
// ****************************************************************
// bench: integer register model and fixed-count settles
// ****************************************************************
module test_pid_sleep_pressure_supervisor import psp_pkg::*;;
    logic clk, resetn, wr, rd, drive_fault, power_module_fault, ext_fault;
    logic decel, fan_hot, pid_sample, pid_hold, pipe_burst_fault;
    logic auto_voltage_regulation, fan_on, brake_on;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, fb_set, pf_set, feedback, pid_freq, rng;
    logic [15:0] vout_cmd, vin, vbus, freq_cmd;
    logic signed [16:0] pid_err;
    int n_fail, n_compared;
    int n_smp = 0; // sample pulses seen from the regulator strobe
    int mdl [32];
    // burst probes: at high, just below high, below low, at low
    logic [15:0] bfb [4] = '{16'h05DC, 16'h05DB, 16'h01F3, 16'h01F4};
    logic [15:0] cfg [18] = '{16'h000A, 16'h03E8, 16'h0001, 16'h0000,
        16'h0123, 16'h0002, 16'h03E8, 16'h0384, 16'h000A, 16'h000A,
        16'h000A, 16'h0000, 16'h05DC, 16'h01F4, 16'h0000, 16'h0005,
        16'h0E10, 16'h0000};
    psp_plant u_plant (.clk, .resetn, .fb_set, .pf_set, .feedback,
        .pid_freq);
    psp_sup #(.TICK_CYCLES(10)) u_dut (.clk, .resetn, .addr, .wdata,
        .wr, .rd, .rdata, .feedback, .pid_freq, .drive_fault,
        .power_module_fault, .ext_fault, .decel, .vout_cmd, .vin, .vbus,
        .fan_hot, .freq_cmd, .pid_err, .pid_sample, .pid_hold,
        .pipe_burst_fault, .auto_voltage_regulation, .fan_on, .brake_on);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // count strobes so sampling can be checked over a whole scenario
    always @(posedge clk) begin
        if (pid_sample === 1'b1) n_smp <= n_smp + 1;
    end
    function automatic logic [15:0] xs();
        rng ^= rng << 7;
        rng ^= rng >> 9;
        rng ^= rng << 8;
        return rng;
    endfunction
    // ends 1 ns past the edge so registered outputs have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [15:0] s, e, input string m);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: %s %h/%h", $time, m, s, e);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a < R_STAT) mdl[a] = (a == R_CTRL) ? d & 16'hFEFF : d;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, mk);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata & mk, e & mk, "read");
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {resetn, wr, rd, drive_fault, power_module_fault} = '0;
        {ext_fault, decel, fan_hot, addr} = '0;
        {wdata, vout_cmd, vin, vbus} = '0;
        fb_set = 16'h03E8;
        pf_set = 16'h0200;
        rng = 16'h7802;
        n_fail = 0;
        n_compared = 0;
        foreach (mdl[i]) mdl[i] = (i < 18) ? int'(cfg[i]) : 0;
        {mdl[2], mdl[3], mdl[4], mdl[5], mdl[15], mdl[17]} = '0;
        {mdl[11], mdl[1]} = '0;
        mdl[R_RINT] = RINT_RST;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        // reset values, then random write-back, unmapped and read-only
        for (int a = 0; a < 18; a++) rd_chk(5'(a), 16'(mdl[a]), 16'hFFFF);
        for (int a = 1; a < 18; a++) wr_reg(5'(a), xs());
        wr_reg(5'h1F, 16'hFFFF);
        wr_reg(R_STAT, 16'h0003);
        for (int a = 0; a < 18; a++) rd_chk(5'(a), 16'(mdl[a]), 16'hFFFF);
        rd_chk(5'h1F, 16'h0000, 16'hFFFF);
        rd_chk(R_STAT, 16'h0000, 16'h0007);
        for (int a = 1; a < 18; a++) wr_reg(5'(a), cfg[a]);
        $display("registers finished");
        // preset frequency first, regulator output after hold
        pf_set <= xs() | 16'h0001;
        wr_reg(R_CTRL, 16'h000B);
        settle(4);
        check(freq_cmd, 16'h0123, "preset");
        rd_chk(R_STAT, 16'h0001, 16'h0007);
        settle(40);
        check(freq_cmd, pf_set, "pid");
        check(16'(pid_hold), 16'h0001, "band hold");
        check(16'(fan_on), 16'h0001, "fan auto");
        rd_chk(R_STAT, 16'h0003, 16'h0007);
        $display("hold finished");
        vin <= 16'h0C80;
        vout_cmd <= 16'h0800;
        for (int m = 0; m < 6; m++) begin
            decel <= (m >= 3);
            wr_reg(R_CTRL, 16'h000B | 16'((m % 3) << 5));
            settle(3);
            check(16'(auto_voltage_regulation),
                16'(m inside {1, 2, 4}), "avr");
        end
        vout_cmd <= 16'h0D00;
        wr_reg(R_CTRL, 16'h002B);
        settle(3);
        check(16'(auto_voltage_regulation), 16'h0000, "avr high");
        for (int i = 0; i < 6; i++) begin
            vbus <= (i == 0) ? 16'h0E10 : (i == 1) ? 16'h0E11 : xs() >> 3;
            settle(3);
            check(16'(brake_on), 16'(vbus > 16'h0E10), "brake");
        end
        check(16'(n_smp), 16'h0000, "band sample");
        $display("avr and brake finished");
        foreach (bfb[i]) begin
            fb_set <= bfb[i];
            settle(4);
            check(16'(pipe_burst_fault), 16'(i % 2 == 0),
                "burst");
            check(freq_cmd, (i % 2) ? pf_set : 16'h0000, "f");
            check(16'(pid_err), 16'(1000 - int'(bfb[i])), "err");
            check(16'(pid_hold), 16'h0000, "no band");
        end
        wr_reg(R_BSDL, 16'h0003);
        fb_set <= 16'h0640;
        settle(18);
        fb_set <= 16'h03E8;
        settle(2);
        fb_set <= 16'h0640;
        settle(18);
        check(16'(pipe_burst_fault), 16'h0000, "restart");
        settle(30);
        check(16'(pipe_burst_fault), 16'h0001, "delayed");
        fb_set <= 16'h03E8;
        wr_reg(R_BSDL, 16'h0000);
        check(16'(n_smp > 0), 16'h0001, "sample");
        $display("burst finished");
        drive_fault <= 1'b1;
        settle(1);
        drive_fault <= 1'b0;
        settle(4);
        check(freq_cmd, 16'h0000, "fault stop");
        settle(400);
        rd_chk(R_STAT, 16'h0004, 16'h0004);
        wr_reg(R_CTRL, 16'h010B);
        settle(4);
        rd_chk(R_STAT, 16'h0000, 16'h0004);
        wr_reg(R_RCNT, RCNT_UNLIM);
        drive_fault <= 1'b1;
        settle(1);
        drive_fault <= 1'b0;
        settle(4);
        rd_chk(R_STAT, 16'h0004, 16'h0004);
        settle(120);
        rd_chk(R_STAT, 16'h0000, 16'h0004);
        for (int k = 0; k < 2; k++) begin
            power_module_fault <= (k == 0);
            ext_fault <= (k == 1);
            settle(1);
            {power_module_fault, ext_fault} <= 2'b00;
            settle(120);
            rd_chk(R_STAT, 16'h0004, 16'h0004);
            wr_reg(R_CTRL, 16'h010B);
        end
        $display("faults finished");
        wr_reg(R_CTRL, 16'h008A);
        settle(3);
        check(16'(fan_on), 16'h0001, "fan on");
        wr_reg(R_CTRL, 16'h000A);
        settle(3);
        check(16'(fan_on), 16'h0000, "fan auto");
        $display("fan finished");
        tally_and_finish();
    end
endmodule // test_pid_sleep_pressure_supervisor
